// >>> hw/wake_pkg.sv
// Constants, field layouts and carrier types of the wake event logger.
// Assumes a 12-bit byte address on the plain register port and one clock.
package wake_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h140;
  localparam logic [11:0] ADDR_SRC    = 12'h144;
  localparam logic [11:0] ADDR_PIN_EN = 12'h148;
  localparam logic [11:0] ADDR_CFG    = 12'h14C;

  // ==========================================================================
  // Wake control/status word bit positions
  localparam int C_BCAST_WAKE_EN   = 0;
  localparam int C_MAGIC_EN   = 1;
  localparam int C_PAT_EN     = 2;
  localparam int C_STA_EN     = 3;
  localparam int C_BCAST_SEEN = 4;
  localparam int C_MAGIC_SEEN = 5;
  localparam int C_PAT_SEEN   = 6;
  localparam int C_STA_SEEN   = 7;
  localparam int C_FE_SEEN    = 9;
  localparam int C_RXI_EN     = 10;
  localparam int C_RXI_SEEN   = 11;
  localparam int C_TXI_EN     = 12;
  localparam int C_TXI_SEEN   = 13;
  localparam int C_FE_EN      = 14;
  localparam logic [31:0] CTRL_EN_MASK  = 32'h0000_540F;
  localparam logic [31:0] CTRL_STS_MASK = 32'h0000_2AF0;

  // ==========================================================================
  // Wake source word bit positions
  localparam int S_PIN_LSB = 20;
  localparam int S_V6      = 16;
  localparam int S_V4      = 15;
  localparam int S_TXI     = 14;
  localparam int S_RXI     = 13;
  localparam int S_FE      = 12;
  localparam int S_STA     = 11;
  localparam int S_MAGIC   = 10;
  localparam int S_BCAST   = 9;
  localparam int S_PAT     = 8;
  localparam int S_IDX_LSB = 0;
  localparam logic [31:0] SRC_MASK = 32'hFFF1_FF1F;
  localparam logic [31:0] IDX_MASK = 32'h0000_001F;

  // ==========================================================================
  // Configuration word and pin enable word
  localparam int G_RES_STS = 0;
  localparam int G_RES_EN  = 1;
  localparam int G_V4_EN   = 2;
  localparam int G_V6_EN   = 3;
  localparam logic [31:0] CFG_MASK    = 32'h0000_000F;
  localparam logic [31:0] PIN_EN_MASK = 32'h0000_0FFF;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam int          PIN_W       = 12;

  // ==========================================================================
  // Suspend phases
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_ENTER  = 2'b01,
    ST_ARMED  = 2'b10,
    ST_WAKING = 2'b11
  } phase_t;

  // Event strobes from MAC, filter engine and idle logic, one cycle each
  typedef struct packed {
    logic       bcast;
    logic       magic;
    logic       pattern;
    logic [4:0] pattern_idx;
    logic       station;
    logic       filter_pass;
    logic       v4_syn;
    logic       v6_syn;
    logic       tx_idle_exit;
    logic       rx_idle_exit;
  } evt_t;

  // Whole state of the logger
  typedef struct packed {
    phase_t            phase;
    logic [31:0]       ctrl;
    logic [31:0]       src;
    logic [31:0]       cfg;
    logic [31:0]       pin_en;
    logic [31:0]       rdata;
    logic              wake;
    logic [PIN_W-1:0]  p1;
    logic [PIN_W-1:0]  p2;
    logic [PIN_W-1:0]  p3;
    logic [PIN_W-1:0]  pin_lvl;
  } state_t;

endpackage : wake_pkg

// >>> hw/wake_event_source_logger.sv
// Wake enables, latched wake status and the wake source record.
// Assumes event strobes on CLOCK, wake pins asynchronous, and a master
// that keeps the plain register port protocol.
//
// Summary of operation
// R1 - Magic packet sets the magic status flag at bit 5; write one clears.
// R2 - Broadcast frame sets the broadcast status flag at bit 4; write one clears.
// R3 - Resume completion clears control status flags when resume-clears-status is set.
// R4 - Resume completion clears the control word wake enables when resume-clears-enables is set; SYN and pin enables stay.
// R5 - Enable bit 3 makes a station address match a wake event.
// R6 - Enable bit 2 makes a pattern filter match a wake event.
// R7 - Enable bit 1 makes a magic packet a wake event.
// R8 - Enable bit 0 makes a broadcast frame a wake event.
// R9 - Wake source register is a 32-bit word at 144h.
// R10 - Events while entering suspend are not recorded as wake sources.
// R11 - After wake-up starts, further events leave the source word unchanged.
// R12 - All conditions met in the waking cycle are recorded together.
// R13 - Source bits stay set until software clears them, except bits 14 and 13 while energy efficient mode is off, and bits 4:0 on a new pattern wake.
// R14 - Bits 31:20 record pin wake events, one bit per pin 11 to 0.
// R15 - Bit 16 records an IPv6 SYN wake, bit 15 an IPv4 SYN wake.
// R16 - Bit 14 records transmit idle exit, only with its wake enable set.
// R17 - Bit 13 records receive idle exit, only with its wake enable set.
// R18 - Both idle exit bits are held low while energy efficient mode is off.
// R19 - Bit 12 records a filter engine frame that caused the wake.
// R20 - Bits 11, 10, 9, 8 record station, magic, broadcast and pattern wakes.
// R21 - Bits 4:0 hold the matching filter index, valid while bit 8 is set.
// R22 - Filter engine enable at bit 14 makes a passing frame a wake event.
// R23 - Software clears status and source bits by writing ones before rearming.
`timescale 1ns/1ps

module wake_event_source_logger (
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RST,
  // Register port
  input  wire logic [11:0]       ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [31:0]       RDATA,
  // Event sources
  input  wire wake_pkg::evt_t    EVT,
  input  wire logic [11:0]       PIN_IN,
  input  wire logic              ENERGY_EFF_ENABLE,
  // Suspend and resume indications
  input  wire logic              SUSPEND_ENTRY,
  input  wire logic              SUSPENDED,
  input  wire logic              RESUME_DONE,
  // Wake signaling request
  output logic                   WAKE_REQ,
  output logic                   WAKE_BUSY
);

  // ==========================================================================
  // State and decode
  wake_pkg::state_t  state_r;
  wake_pkg::state_t  state_nxt;
  logic              wr_ctrl;
  logic              wr_src;
  logic [11:0]       pin_rise;
  logic [31:0]       src_set;
  logic [31:0]       sts_set;
  logic              any_hit;
  logic              fire;

  // Write decode
  assign wr_ctrl = WR && (ADDR == wake_pkg::ADDR_CTRL);
  assign wr_src  = WR && (ADDR == wake_pkg::ADDR_SRC);

  // ==========================================================================
  // Event qualification
  always_comb begin
    // Pin rises once the second and third stages agree high
    pin_rise = state_r.p2 & state_r.p3 & ~state_r.pin_lvl;
    src_set  = wake_pkg::RST_WORD;
    sts_set  = wake_pkg::RST_WORD;
    // Sources that would cause wake signaling now
    src_set[wake_pkg::S_PIN_LSB +: wake_pkg::PIN_W] =
      pin_rise & state_r.pin_en[wake_pkg::PIN_W-1:0];                        // see R14
    src_set[wake_pkg::S_V6]    = EVT.v6_syn & state_r.cfg[wake_pkg::G_V6_EN]; // see R15
    src_set[wake_pkg::S_V4]    = EVT.v4_syn & state_r.cfg[wake_pkg::G_V4_EN]; // see R15
    src_set[wake_pkg::S_TXI]   = EVT.tx_idle_exit & state_r.ctrl[wake_pkg::C_TXI_EN]
                                 & ENERGY_EFF_ENABLE;                         // see R16
    src_set[wake_pkg::S_RXI]   = EVT.rx_idle_exit & state_r.ctrl[wake_pkg::C_RXI_EN]
                                 & ENERGY_EFF_ENABLE;                         // see R17
    src_set[wake_pkg::S_FE]    = EVT.filter_pass & state_r.ctrl[wake_pkg::C_FE_EN]; // see R19 R22
    src_set[wake_pkg::S_STA]   = EVT.station & state_r.ctrl[wake_pkg::C_STA_EN];    // see R5 R20
    src_set[wake_pkg::S_MAGIC] = EVT.magic & state_r.ctrl[wake_pkg::C_MAGIC_EN];    // see R7 R20
    src_set[wake_pkg::S_BCAST] = EVT.bcast & state_r.ctrl[wake_pkg::C_BCAST_WAKE_EN];    // see R8 R20
    src_set[wake_pkg::S_PAT]   = EVT.pattern & state_r.ctrl[wake_pkg::C_PAT_EN];    // see R6 R20
    any_hit = |src_set;
    // Filter index rides along with a pattern wake
    if (src_set[wake_pkg::S_PAT]) begin
      src_set[wake_pkg::S_IDX_LSB +: 5] = EVT.pattern_idx;                  // see R21
    end
    // Control status flags latch whether or not a wake follows
    sts_set[wake_pkg::C_MAGIC_SEEN] = EVT.magic;                            // see R1
    sts_set[wake_pkg::C_BCAST_SEEN] = EVT.bcast;                            // see R2
    sts_set[wake_pkg::C_PAT_SEEN]   = EVT.pattern;
    sts_set[wake_pkg::C_STA_SEEN]   = EVT.station;
    sts_set[wake_pkg::C_FE_SEEN]    = EVT.filter_pass;
    sts_set[wake_pkg::C_TXI_SEEN]   = EVT.tx_idle_exit & state_r.ctrl[wake_pkg::C_TXI_EN];
    sts_set[wake_pkg::C_RXI_SEEN]   = EVT.rx_idle_exit & state_r.ctrl[wake_pkg::C_RXI_EN];
  end

  // Only an armed suspend records and signals a wake
  assign fire = (state_r.phase == wake_pkg::ST_ARMED) && any_hit;           // see R10 R11

  // ==========================================================================
  // Next state
  always_comb begin
    state_nxt = state_r;
    // Pin synchroniser, agreement filter
    state_nxt.p1 = PIN_IN;
    state_nxt.p2 = state_r.p1;
    state_nxt.p3 = state_r.p2;
    for (int i = 0; i < wake_pkg::PIN_W; i++) begin
      if (state_r.p2[i] == state_r.p3[i]) begin
        state_nxt.pin_lvl[i] = state_r.p3[i];
      end
    end

    // Control word: enables plain, status flags write-one-to-clear
    state_nxt.ctrl = (state_r.ctrl & wake_pkg::CTRL_STS_MASK)
                   & ~(wr_ctrl ? WDATA : wake_pkg::RST_WORD);               // see R1 R2 R23
    if (wr_ctrl) begin
      state_nxt.ctrl = state_nxt.ctrl | (WDATA & wake_pkg::CTRL_EN_MASK);
    end else begin
      state_nxt.ctrl = state_nxt.ctrl | (state_r.ctrl & wake_pkg::CTRL_EN_MASK);
    end
    if (RESUME_DONE && state_r.cfg[wake_pkg::G_RES_EN]) begin
      state_nxt.ctrl = state_nxt.ctrl & ~wake_pkg::CTRL_EN_MASK;            // see R4
    end
    if (RESUME_DONE && state_r.cfg[wake_pkg::G_RES_STS]) begin
      state_nxt.ctrl = state_nxt.ctrl & ~wake_pkg::CTRL_STS_MASK;           // see R3
    end
    // New events win over a clear in the same cycle
    state_nxt.ctrl = state_nxt.ctrl | sts_set;
    if (!ENERGY_EFF_ENABLE) begin
      state_nxt.ctrl[wake_pkg::C_TXI_SEEN] = 1'b0;
      state_nxt.ctrl[wake_pkg::C_RXI_SEEN] = 1'b0;
    end

    // Source word: only software clears it, except the idle exit bits while energy efficient mode is off and bits 4:0 on a new pattern wake
    state_nxt.src = state_r.src & ~(wr_src ? WDATA : wake_pkg::RST_WORD);   // see R13 R23
    if (fire) begin
      if (src_set[wake_pkg::S_PAT]) begin
        state_nxt.src = state_nxt.src & ~wake_pkg::IDX_MASK;
      end
      state_nxt.src = state_nxt.src | src_set;                              // see R12
    end
    state_nxt.src = state_nxt.src & wake_pkg::SRC_MASK;                     // see R9
    if (!ENERGY_EFF_ENABLE) begin
      state_nxt.src[wake_pkg::S_TXI] = 1'b0;                                // see R18
      state_nxt.src[wake_pkg::S_RXI] = 1'b0;                                // see R18
    end

    // Configuration and pin enables
    if (WR && (ADDR == wake_pkg::ADDR_CFG)) begin
      state_nxt.cfg = WDATA & wake_pkg::CFG_MASK;
    end
    if (WR && (ADDR == wake_pkg::ADDR_PIN_EN)) begin
      state_nxt.pin_en = WDATA & wake_pkg::PIN_EN_MASK;
    end

    // Suspend phase tracking
    case (state_r.phase)
      wake_pkg::ST_RUN: begin
        if (SUSPEND_ENTRY) begin
          state_nxt.phase = wake_pkg::ST_ENTER;                             // see R10
        end
      end
      wake_pkg::ST_ENTER: begin
        if (!SUSPEND_ENTRY && SUSPENDED) begin
          state_nxt.phase = wake_pkg::ST_ARMED;
        end else if (!SUSPEND_ENTRY) begin
          state_nxt.phase = wake_pkg::ST_RUN;
        end
      end
      wake_pkg::ST_ARMED: begin
        if (fire) begin
          state_nxt.phase = wake_pkg::ST_WAKING;                            // see R11
        end else if (!SUSPENDED || RESUME_DONE) begin
          state_nxt.phase = wake_pkg::ST_RUN;
        end
      end
      wake_pkg::ST_WAKING: begin
        if (RESUME_DONE) begin
          state_nxt.phase = wake_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt.phase = wake_pkg::ST_RUN;
      end
    endcase
    state_nxt.wake = fire;

    // Read data stands only in the cycle after the strobe
    state_nxt.rdata = wake_pkg::RST_WORD;
    if (RD) begin
      case (ADDR)
        wake_pkg::ADDR_CTRL:   state_nxt.rdata = state_r.ctrl;
        wake_pkg::ADDR_SRC:    state_nxt.rdata = state_r.src;               // see R9
        wake_pkg::ADDR_PIN_EN: state_nxt.rdata = state_r.pin_en;
        wake_pkg::ADDR_CFG:    state_nxt.rdata = state_r.cfg;
        default:               state_nxt.rdata = wake_pkg::RST_WORD;
      endcase
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs
  assign RDATA     = state_r.rdata;
  assign WAKE_REQ  = state_r.wake;
  assign WAKE_BUSY = (state_r.phase == wake_pkg::ST_WAKING);

  // ==========================================================================
  // Assertions
  property p_magic_flag;
    @(posedge CLOCK) disable iff (RST)
    EVT.magic |=> state_r.ctrl[wake_pkg::C_MAGIC_SEEN];
  endproperty
  a_magic_flag: assert property (p_magic_flag) else $error("magic flag not set"); // see R1

  property p_bcast_flag;
    @(posedge CLOCK) disable iff (RST)
    EVT.bcast |=> state_r.ctrl[wake_pkg::C_BCAST_SEEN];
  endproperty
  a_bcast_flag: assert property (p_bcast_flag) else $error("broadcast flag not set"); // see R2

  property p_resume_sts;
    @(posedge CLOCK) disable iff (RST)
    (RESUME_DONE && state_r.cfg[wake_pkg::G_RES_STS] && !EVT.magic)
      |=> !state_r.ctrl[wake_pkg::C_MAGIC_SEEN];
  endproperty
  a_resume_sts: assert property (p_resume_sts) else $error("status kept over resume"); // see R3

  property p_resume_en;
    @(posedge CLOCK) disable iff (RST)
    (RESUME_DONE && state_r.cfg[wake_pkg::G_RES_EN])
      |=> ((state_r.ctrl & wake_pkg::CTRL_EN_MASK) == wake_pkg::RST_WORD);
  endproperty
  a_resume_en: assert property (p_resume_en) else $error("enables kept over resume"); // see R4

  property p_no_record;
    @(posedge CLOCK) disable iff (RST)
    (state_r.phase != wake_pkg::ST_ARMED) |=> ((state_r.src & ~$past(state_r.src)) == 0);
  endproperty
  a_no_record: assert property (p_no_record) else $error("source recorded outside armed"); // see R10 R11

  property p_all_sources;
    @(posedge CLOCK) disable iff (RST)
    fire ##1 1'b1 |-> ((state_r.src & $past(src_set)) == $past(src_set)) && WAKE_REQ && WAKE_BUSY;
  endproperty
  a_all_sources: assert property (p_all_sources) else $error("wake sources incomplete"); // see R12

  property p_sticky;
    @(posedge CLOCK) disable iff (RST)
    (!wr_src && ENERGY_EFF_ENABLE) |=> (($past(state_r.src) & ~state_r.src) == 0);
  endproperty
  a_sticky: assert property (p_sticky) else $error("source bit dropped by hardware"); // see R13

  property p_eee_low;
    @(posedge CLOCK) disable iff (RST)
    !ENERGY_EFF_ENABLE |=> !state_r.src[wake_pkg::S_TXI] && !state_r.src[wake_pkg::S_RXI];
  endproperty
  a_eee_low: assert property (p_eee_low) else $error("idle exit source not held low"); // see R18

  property p_tx_gate;
    @(posedge CLOCK) disable iff (RST)
    $rose(state_r.src[wake_pkg::S_TXI]) |-> $past(state_r.ctrl[wake_pkg::C_TXI_EN]);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx idle source without enable"); // see R16

  property p_index;
    @(posedge CLOCK) disable iff (RST)
    (fire && src_set[wake_pkg::S_PAT])
      |=> state_r.src[wake_pkg::S_PAT] && (state_r.src[4:0] == $past(EVT.pattern_idx));
  endproperty
  a_index: assert property (p_index) else $error("filter index wrong"); // see R21

  property p_station_wake;
    @(posedge CLOCK) disable iff (RST)
    ((state_r.phase == wake_pkg::ST_ARMED) && EVT.station && state_r.ctrl[wake_pkg::C_STA_EN])
      |=> WAKE_REQ && state_r.src[wake_pkg::S_STA];
  endproperty
  a_station_wake: assert property (p_station_wake) else $error("station match no wake"); // see R5

  property p_pattern_wake;
    @(posedge CLOCK) disable iff (RST)
    ((state_r.phase == wake_pkg::ST_ARMED) && EVT.pattern && state_r.ctrl[wake_pkg::C_PAT_EN])
      |=> WAKE_REQ && state_r.src[wake_pkg::S_PAT];
  endproperty
  a_pattern_wake: assert property (p_pattern_wake) else $error("pattern match no wake"); // see R6

  property p_magic_wake;
    @(posedge CLOCK) disable iff (RST)
    ((state_r.phase == wake_pkg::ST_ARMED) && EVT.magic && state_r.ctrl[wake_pkg::C_MAGIC_EN])
      |=> WAKE_REQ && state_r.src[wake_pkg::S_MAGIC];
  endproperty
  a_magic_wake: assert property (p_magic_wake) else $error("magic packet no wake"); // see R7

  property p_bcast_wake;
    @(posedge CLOCK) disable iff (RST)
    ((state_r.phase == wake_pkg::ST_ARMED) && EVT.bcast && state_r.ctrl[wake_pkg::C_BCAST_WAKE_EN])
      |=> WAKE_REQ && state_r.src[wake_pkg::S_BCAST];
  endproperty
  a_bcast_wake: assert property (p_bcast_wake) else $error("broadcast no wake"); // see R8

  property p_fe_wake;
    @(posedge CLOCK) disable iff (RST)
    ((state_r.phase == wake_pkg::ST_ARMED) && EVT.filter_pass && state_r.ctrl[wake_pkg::C_FE_EN])
      |=> WAKE_REQ && state_r.src[wake_pkg::S_FE];
  endproperty
  a_fe_wake: assert property (p_fe_wake) else $error("filter frame no wake"); // see R22

  property p_pin_gate;
    @(posedge CLOCK) disable iff (RST)
    $rose(state_r.src[wake_pkg::S_PIN_LSB + wake_pkg::PIN_W - 1]) |-> $past(state_r.pin_en[wake_pkg::PIN_W - 1]);
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin source without enable"); // see R14

  property p_v4_gate;
    @(posedge CLOCK) disable iff (RST)
    $rose(state_r.src[wake_pkg::S_V4]) |-> $past(EVT.v4_syn && state_r.cfg[wake_pkg::G_V4_EN]);
  endproperty
  a_v4_gate: assert property (p_v4_gate) else $error("v4 source without event"); // see R15

  property p_v6_gate;
    @(posedge CLOCK) disable iff (RST)
    $rose(state_r.src[wake_pkg::S_V6]) |-> $past(EVT.v6_syn && state_r.cfg[wake_pkg::G_V6_EN]);
  endproperty
  a_v6_gate: assert property (p_v6_gate) else $error("v6 source without event"); // see R15

  property p_rx_gate;
    @(posedge CLOCK) disable iff (RST)
    $rose(state_r.src[wake_pkg::S_RXI]) |-> $past(state_r.ctrl[wake_pkg::C_RXI_EN] && ENERGY_EFF_ENABLE);
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx idle source without enable"); // see R17

  property p_fe_src;
    @(posedge CLOCK) disable iff (RST)
    $rose(state_r.src[wake_pkg::S_FE]) |-> $past(EVT.filter_pass);
  endproperty
  a_fe_src: assert property (p_fe_src) else $error("filter source without frame"); // see R19

  property p_with_wake;
    @(posedge CLOCK) disable iff (RST)
    ((state_r.src & ~$past(state_r.src)) != wake_pkg::RST_WORD) |-> WAKE_REQ;
  endproperty
  a_with_wake: assert property (p_with_wake) else $error("source set without wake"); // see R20

  property p_magic_clear;
    @(posedge CLOCK) disable iff (RST)
    (wr_ctrl && WDATA[wake_pkg::C_MAGIC_SEEN] && !EVT.magic)
      |=> !state_r.ctrl[wake_pkg::C_MAGIC_SEEN];
  endproperty
  a_magic_clear: assert property (p_magic_clear) else $error("magic flag not cleared"); // see R1

  property p_src_read;
    @(posedge CLOCK) disable iff (RST)
    (RD && (ADDR == wake_pkg::ADDR_SRC)) |=> (RDATA == $past(state_r.src));
  endproperty
  a_src_read: assert property (p_src_read) else $error("source read wrong"); // see R9

endmodule : wake_event_source_logger

// >>> bench/event_source_model.sv
// Far-side model: MAC, filter engine, idle logic, wake pins and suspend control.
// Assumes the bench calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps

module event_source_model (
  // Clock
  input  wire logic           clock,
  // Event strobes and levels
  output wake_pkg::evt_t      evt,
  output logic [11:0]         pin_in,
  output logic                energy_eff_enable,
  // Suspend and resume indications
  output logic                suspend_entry,
  output logic                suspended,
  output logic                resume_done
);
  // ==========================================================================
  // Idle levels at time zero
  initial begin
    evt               = '0;
    pin_in            = 12'h000;
    energy_eff_enable = 1'b1;
    suspend_entry     = 1'b0;
    suspended         = 1'b0;
    resume_done       = 1'b0;
  end

  // One-cycle strobe of the given events
  task automatic fire(input wake_pkg::evt_t e);
    @(posedge clock) evt <= e;
    @(posedge clock) evt <= '0;
  endtask : fire

  // Suspend entry with optional events during entry, then armed
  task automatic arm(input wake_pkg::evt_t e);
    @(posedge clock) suspend_entry <= 1'b1;
    @(posedge clock) evt <= e;
    @(posedge clock) begin
      evt           <= '0;
      suspend_entry <= 1'b0;
      suspended     <= 1'b1;
    end
    @(posedge clock);
  endtask : arm

  // Leave suspend with a resume completion pulse
  task automatic resume();
    @(posedge clock) begin
      suspended   <= 1'b0;
      resume_done <= 1'b1;
    end
    @(posedge clock) resume_done <= 1'b0;
    @(posedge clock);
  endtask : resume
endmodule : event_source_model

// >>> bench/tb_top.sv
// Self-checking bench of the wake event logger.
// Assumes the far-side model above and the plain register port.
`timescale 1ns/1ps

module tb_top;
  // ==========================================================================
  // Signals
  logic           clk = 1'b0;
  logic           rst = 1'b1;
  logic [11:0]    addr = 12'h000;
  logic [31:0]    wdata = 32'h0000_0000;
  logic           wr = 1'b0;
  logic           rd = 1'b0;
  logic [31:0]    rdata;
  wake_pkg::evt_t evt;
  wake_pkg::evt_t e;
  logic [11:0]    pins;
  logic           eee, s_ent, s_on, res_done, wake_req, wake_busy;
  int             n_errors = 0;
  int             n_checks = 0;
  int             cyc = 0;

  // Clock and timeout
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Instances
  wake_event_source_logger dut_u (
    .CLOCK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .EVT(evt), .PIN_IN(pins), .ENERGY_EFF_ENABLE(eee), .SUSPEND_ENTRY(s_ent),
    .SUSPENDED(s_on), .RESUME_DONE(res_done), .WAKE_REQ(wake_req), .WAKE_BUSY(wake_busy));
  event_source_model src_u (
    .clock(clk), .evt(evt), .pin_in(pins), .energy_eff_enable(eee),
    .suspend_entry(s_ent), .suspended(s_on), .resume_done(res_done));

  // ==========================================================================
  // Compare, access and report tasks
  task automatic chk_word(input string n, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string n, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", n, exp, got);
    end
  endtask : chk_flag

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) begin
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input string n, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk) begin
      addr <= a;
      rd   <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    #1 chk_word(n, exp, rdata);
  endtask : rd_reg

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // ==========================================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    rd_reg("ctrl", wake_pkg::ADDR_CTRL, 32'h0000_0000);
    rd_reg("src", wake_pkg::ADDR_SRC, 32'h0000_0000);
    rd_reg("pin_en", wake_pkg::ADDR_PIN_EN, 32'h0000_0000);
    rd_reg("cfg", wake_pkg::ADDR_CFG, 32'h0000_0000);
    rd_reg("unmapped", 12'h150, 32'h0000_0000);
    wr_reg(wake_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
    rd_reg("ctrl_rw", wake_pkg::ADDR_CTRL, wake_pkg::CTRL_EN_MASK);
    wr_reg(wake_pkg::ADDR_CTRL, 32'h0000_0000);
    $display("test reset done");
    // Status flags outside suspend, idle exit gated by its enable
    e = '0;
    e.bcast = 1'b1;
    e.magic = 1'b1;
    e.tx_idle_exit = 1'b1;
    src_u.fire(e);
    #1 chk_flag("req_run", 1'b0, wake_req);
    rd_reg("ctrl_sts", wake_pkg::ADDR_CTRL, 32'h0000_0030);
    wr_reg(wake_pkg::ADDR_CTRL, 32'h0000_0010);
    rd_reg("ctrl_w1c", wake_pkg::ADDR_CTRL, 32'h0000_0020);
    wr_reg(wake_pkg::ADDR_CTRL, 32'h0000_0020);
    rd_reg("src_run", wake_pkg::ADDR_SRC, 32'h0000_0000);
    $display("test status done");
    // Event during suspend entry is not a wake source
    wr_reg(wake_pkg::ADDR_CTRL, 32'h0000_0002);
    e = '0;
    e.magic = 1'b1;
    src_u.arm(e);
    #1 chk_flag("req_enter", 1'b0, wake_req);
    src_u.resume();
    rd_reg("src_enter", wake_pkg::ADDR_SRC, 32'h0000_0000);
    wr_reg(wake_pkg::ADDR_CTRL, 32'h0000_0020);
    $display("test entry done");
    // One packet meeting several conditions, later events ignored, resume clears
    wr_reg(wake_pkg::ADDR_CFG, 32'h0000_0003);
    wr_reg(wake_pkg::ADDR_CTRL, 32'h0000_400F);
    src_u.arm('0);
    e = '0;
    e.bcast = 1'b1;
    e.magic = 1'b1;
    e.pattern = 1'b1;
    e.pattern_idx = 5'h15;
    e.station = 1'b1;
    e.filter_pass = 1'b1;
    e.v4_syn = 1'b1;
    e.tx_idle_exit = 1'b1;
    src_u.fire(e);
    #1 chk_flag("req_multi", 1'b1, wake_req);
    chk_flag("busy_multi", 1'b1, wake_busy);
    e = '0;
    e.pattern = 1'b1;
    e.pattern_idx = 5'h0A;
    src_u.fire(e);
    #1 chk_flag("req_again", 1'b0, wake_req);
    rd_reg("src_multi", wake_pkg::ADDR_SRC, 32'h0000_1F15);
    rd_reg("ctrl_multi", wake_pkg::ADDR_CTRL, 32'h0000_42FF);
    src_u.resume();
    #1 chk_flag("busy_res", 1'b0, wake_busy);
    rd_reg("ctrl_res", wake_pkg::ADDR_CTRL, 32'h0000_0000);
    rd_reg("src_kept", wake_pkg::ADDR_SRC, 32'h0000_1F15);
    @(posedge clk) #1 chk_word("rdata_idle", 32'h0000_0000, rdata);
    wr_reg(wake_pkg::ADDR_SRC, 32'hFFFF_FFFF);
    rd_reg("src_w1c", wake_pkg::ADDR_SRC, 32'h0000_0000);
    $display("test multi done");
    // SYN and idle exit sources, then energy saving switched off
    wr_reg(wake_pkg::ADDR_CFG, 32'h0000_000C);
    wr_reg(wake_pkg::ADDR_CTRL, 32'h0000_1400);
    src_u.arm('0);
    e = '0;
    e.v4_syn = 1'b1;
    e.v6_syn = 1'b1;
    e.tx_idle_exit = 1'b1;
    e.rx_idle_exit = 1'b1;
    e.bcast = 1'b1;
    e.magic = 1'b1;
    src_u.fire(e);
    rd_reg("src_syn", wake_pkg::ADDR_SRC, 32'h0001_E000);
    rd_reg("ctrl_idle", wake_pkg::ADDR_CTRL, 32'h0000_3C30);
    @(posedge clk) src_u.energy_eff_enable <= 1'b0;
    rd_reg("src_eee", wake_pkg::ADDR_SRC, 32'h0001_8000);
    rd_reg("ctrl_eee", wake_pkg::ADDR_CTRL, 32'h0000_1430);
    src_u.resume();
    wr_reg(wake_pkg::ADDR_SRC, 32'hFFFF_FFFF);
    @(posedge clk) src_u.energy_eff_enable <= 1'b1;
    $display("test syn done");
    // Pin wake events, highest and lowest pin
    wr_reg(wake_pkg::ADDR_PIN_EN, 32'h0000_0FFF);
    src_u.arm('0);
    @(posedge clk) src_u.pin_in <= 12'h801;
    for (int i = 0; i < 10 && wake_req !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk_flag("req_pin", 1'b1, wake_req);
    rd_reg("src_pin", wake_pkg::ADDR_SRC, 32'h8010_0000);
    src_u.resume();
    $display("test pins done");
    summarize();
  end
endmodule : tb_top
